/* File: src/wsh_steering.sv */
/*
  Watchdog expiry steering and external interrupt masking, with an Avalon-MM slave.
  Assumes a separate watchdog counter that supplies an expiry pulse and an enable level,
  and external interrupt pins already synchronous to clock.
*/
`timescale 1ns/100ps

module wsh_steering
  import wsh_pkg::*;
#(
  parameter int NUM_SECONDARY = NUM_SEC
) (
  input wire logic clock,
  input wire logic reset,
  input wire wsh_req_s busReq,
  output wsh_rsp_s busRsp,
  input wire logic highPrioIrqIn_n,
  input wire logic [NUM_SECONDARY-1:0] secIrqIn_n,
  input wire logic watchdogExpire,
  input wire logic watchdogEnabled,
  output logic normalIrq,
  output logic fastIrq,
  output logic [1:0] watchdogPriority,
  output logic chipResetReq,
  output logic eventIrq
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The source map is fixed by the package, so a parameter or constant that breaks it
  // stops elaboration instead of leaving a source silently unmapped or doubly mapped.
  if (NUM_SECONDARY != NUM_SEC) begin : g_chk_secondary
    $error("wsh_steering supports exactly four secondary inputs");
  end

  if (BIT_SEC_LO + NUM_SEC > BIT_WATCHDOG) begin : g_chk_sec_overlap
    $error("secondary sources overlap the watchdog source bit");
  end

  if (BIT_HIGH_PRIO <= BIT_WATCHDOG || BIT_HIGH_PRIO > 31) begin : g_chk_high_prio
    $error("high priority source bit lies outside the upper source field");
  end

  // The watchdog source is cleared through byte lane 2 only.
  if (BIT_WATCHDOG / 8 != 2) begin : g_chk_clear_lane
    $error("watchdog source bit must sit in byte lane 2");
  end

  if (PRIO_WDOG_HI != PRIO_WDOG_LO + 1) begin : g_chk_prio_field
    $error("watchdog priority field must be two bits wide");
  end

  // Event status and mask are written through lane 0, so every event bit must fit there.
  if (NUM_EVT > 8) begin : g_chk_evt_lane
    $error("event bits must fit in byte lane 0");
  end

  if (EVT_RESET_TAKEN >= NUM_EVT || EVT_IRQ_TAKEN >= NUM_EVT || EVT_UNMAPPED >= NUM_EVT) begin : g_chk_evt_bits
    $error("event bit position beyond the event field");
  end

  // The decode compares all five address bits, so offsets must be word addresses.
  if ((OFS_CONTROL_0[1:0] | OFS_CONTROL_1[1:0] | OFS_STEERING_0[1:0] | OFS_NORMAL_SRC_0[1:0]
       | OFS_FAST_SRC_0[1:0] | OFS_PRIORITY_1[1:0] | OFS_EVENT_STATUS[1:0] | OFS_EVENT_MASK[1:0])
      != 2'h0) begin : g_chk_aligned
    $error("register offsets must be word aligned");
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] control0;
  logic [31:0] control1;
  logic [31:0] steering0;
  logic [31:0] priority1;
  logic [NUM_EVT-1:0] evtStatus;
  logic [NUM_EVT-1:0] evtMask;
  logic watchdogPending;
  logic ackPhase;
  logic [31:0] readData;

  logic busAccess;
  logic wrStrobe;
  logic rdTake;
  logic unmapped;
  logic [31:0] byteMask;
  logic [31:0] rawSrc;
  logic [31:0] enabledSrc;
  logic [31:0] normalSrc;
  logic [31:0] fastSrc;
  logic expiryValid;
  logic expiryToIrq;
  logic expiryToReset;
  logic [NUM_EVT-1:0] evtSet;
  logic [NUM_EVT-1:0] evtClear;
  logic wrControl0;
  logic wrControl1;
  logic wrSteering0;
  logic wrPriority1;
  logic wrEventMask;
  logic wrEventStatus;
  logic wrSourceClear;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // Every access takes two cycles: waitrequest is low in the cycle after the request is seen,
  // which gives read data a full cycle out of a flop and keeps the write edge unique.
  assign busAccess = busReq.read | busReq.write;
  assign busRsp.waitrequest = ~ackPhase;
  assign busRsp.readdata = readData;
  assign wrStrobe = busReq.write & ackPhase;
  assign rdTake = busReq.read & ~ackPhase;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ackPhase <= 1'b0;
    end else begin
      ackPhase <= busAccess & ~ackPhase;
    end
  end

  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_lane
      assign byteMask[gb*8 +: 8] = {8{busReq.byteenable[gb]}};
    end
  endgenerate

  always_comb begin
    unmapped = 1'b0;
    case (busReq.address)
      OFS_CONTROL_0, OFS_CONTROL_1, OFS_STEERING_0, OFS_NORMAL_SRC_0,
      OFS_FAST_SRC_0, OFS_PRIORITY_1, OFS_EVENT_STATUS, OFS_EVENT_MASK: unmapped = 1'b0;
      default: unmapped = 1'b1;
    endcase
  end

  // One strobe per writable location; each lands only at the edge where waitrequest is low.
  // Writes to read-only or unmapped words match no strobe and are dropped.
  // The event words and the source clear look at their single byte lane only.
  assign wrControl0 = wrStrobe && busReq.address == OFS_CONTROL_0;
  assign wrControl1 = wrStrobe && busReq.address == OFS_CONTROL_1;
  assign wrSteering0 = wrStrobe && busReq.address == OFS_STEERING_0;
  assign wrPriority1 = wrStrobe && busReq.address == OFS_PRIORITY_1;
  assign wrEventMask = wrStrobe && busReq.address == OFS_EVENT_MASK && busReq.byteenable[0];
  assign wrEventStatus = wrStrobe && busReq.address == OFS_EVENT_STATUS && busReq.byteenable[0];
  assign wrSourceClear = wrStrobe && busReq.address == OFS_NORMAL_SRC_0 && busReq.byteenable[2]
                         && busReq.writedata[BIT_WATCHDOG];

  // ----------------------------------------------------------------
  // Interrupt sources
  // ----------------------------------------------------------------
  // The high priority pin is treated as one more ordinary active-low source.
  always_comb begin
    rawSrc = 32'h0000_0000;
    rawSrc[BIT_HIGH_PRIO] = ~highPrioIrqIn_n;
    rawSrc[BIT_SEC_LO +: NUM_SEC] = ~secIrqIn_n;
    rawSrc[BIT_WATCHDOG] = watchdogPending;
  end

  // Pins are masked by the second control register, the watchdog by the first.
  always_comb begin
    enabledSrc = rawSrc & control1;
    enabledSrc[BIT_WATCHDOG] = rawSrc[BIT_WATCHDOG] & control0[BIT_WATCHDOG];
    fastSrc = enabledSrc & steering0;
    normalSrc = enabledSrc & ~steering0;
  end

  assign normalIrq = |normalSrc;
  assign fastIrq = |fastSrc;
  assign watchdogPriority = priority1[PRIO_WDOG_HI:PRIO_WDOG_LO];

  // ----------------------------------------------------------------
  // Watchdog expiry steering
  // ----------------------------------------------------------------
  // An expiry from a counter that is not enabled is ignored, so nothing fires before
  // software has run the enabling sequence in the counter block.
  assign expiryValid = watchdogExpire & watchdogEnabled;
  assign expiryToIrq = expiryValid & control0[BIT_WATCHDOG];
  assign expiryToReset = expiryValid & ~control0[BIT_WATCHDOG];

  // The reset request is a one-cycle pulse from a flop; the chip reset logic stretches it.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      chipResetReq <= 1'b0;
    end else begin
      chipResetReq <= expiryToReset;
    end
  end

  // Pending is a sticky interrupt bit; it is cleared by writing a one to the source register.
  // A new expiry in the clearing cycle wins over the clear.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      watchdogPending <= 1'b0;
    end else if (expiryToIrq) begin
      watchdogPending <= 1'b1;
    end else if (wrSourceClear) begin
      watchdogPending <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Each register has its own process, and a write touches only its enabled byte lanes.
  // All masks reset clear, so every source, the high priority pin included, starts masked,
  // and a watchdog expiry starts out steered to chip reset.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      control0 <= RST_CONTROL;
    end else if (wrControl0) begin
      control0 <= (control0 & ~byteMask) | (busReq.writedata & byteMask);
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      control1 <= RST_CONTROL;
    end else if (wrControl1) begin
      control1 <= (control1 & ~byteMask) | (busReq.writedata & byteMask);
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      steering0 <= RST_STEERING;
    end else if (wrSteering0) begin
      steering0 <= (steering0 & ~byteMask) | (busReq.writedata & byteMask);
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      priority1 <= RST_PRIORITY;
    end else if (wrPriority1) begin
      priority1 <= (priority1 & ~byteMask) | (busReq.writedata & byteMask);
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      evtMask <= RST_EVT_MASK[NUM_EVT-1:0];
    end else if (wrEventMask) begin
      evtMask <= busReq.writedata[NUM_EVT-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Block events and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    evtSet = '0;
    evtSet[EVT_RESET_TAKEN] = expiryToReset;
    evtSet[EVT_IRQ_TAKEN] = expiryToIrq;
    evtSet[EVT_UNMAPPED] = busAccess & ~ackPhase & unmapped;
    evtClear = '0;
    if (wrEventStatus) begin
      evtClear = busReq.writedata[NUM_EVT-1:0];
    end
  end

  // Set has priority over write-one-to-clear in the same cycle.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      evtStatus <= '0;
    end else begin
      evtStatus <= (evtStatus & ~evtClear) | evtSet;
    end
  end

  assign eventIrq = |(evtStatus & evtMask);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      readData <= 32'h0000_0000;
    end else if (rdTake) begin
      case (busReq.address)
        OFS_CONTROL_0: readData <= control0;
        OFS_CONTROL_1: readData <= control1;
        OFS_STEERING_0: readData <= steering0;
        OFS_NORMAL_SRC_0: readData <= normalSrc;
        OFS_FAST_SRC_0: readData <= fastSrc;
        OFS_PRIORITY_1: readData <= priority1;
        OFS_EVENT_STATUS: readData <= {{(32-NUM_EVT){1'b0}}, evtStatus};
        OFS_EVENT_MASK: readData <= {{(32-NUM_EVT){1'b0}}, evtMask};
        default: readData <= READ_UNMAPPED;
      endcase
    end
  end

endmodule

/* File: src/wsh_pkg.sv */
/*
  Package for the watchdog steering and high priority interrupt masking block.
  Holds register offsets, field positions, reset values and the bus carrier structs.
  Assumes a 32-bit Avalon-MM register bus with word-aligned byte addresses.
*/
package wsh_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_CONTROL_0 = 5'h00;   // irq_control_reg_0
  localparam logic [4:0] OFS_CONTROL_1 = 5'h04;   // irq_control_reg_1
  localparam logic [4:0] OFS_STEERING_0 = 5'h08;  // irq_steering_reg_0
  localparam logic [4:0] OFS_NORMAL_SRC_0 = 5'h0c; // normal_irq_source_reg_0
  localparam logic [4:0] OFS_FAST_SRC_0 = 5'h10;  // fast_irq_source_reg_0
  localparam logic [4:0] OFS_PRIORITY_1 = 5'h14;  // irq_priority_reg_1
  localparam logic [4:0] OFS_EVENT_STATUS = 5'h18;
  localparam logic [4:0] OFS_EVENT_MASK = 5'h1c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_WATCHDOG = 17;
  localparam int BIT_HIGH_PRIO = 31;
  localparam int BIT_SEC_LO = 0;
  localparam int NUM_SEC = 4;
  localparam int PRIO_WDOG_LO = 2;
  localparam int PRIO_WDOG_HI = 3;

  // Event status bits of the block's own interrupt register.
  localparam int EVT_RESET_TAKEN = 0;
  localparam int EVT_IRQ_TAKEN = 1;
  localparam int EVT_UNMAPPED = 2;
  localparam int NUM_EVT = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_CONTROL = 32'h0000_0000;
  localparam logic [31:0] RST_STEERING = 32'h0000_0000;
  localparam logic [31:0] RST_PRIORITY = 32'h0000_0000;
  localparam logic [31:0] RST_EVT_MASK = 32'h0000_0000;
  localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic read;
    logic write;
    logic [4:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } wsh_req_s;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } wsh_rsp_s;

endpackage

/* File: dv/wsh_steering_properties.sv */
/* Port checker for wsh_steering.
   Assumes register writes take effect at the edge where waitrequest is low. */
`timescale 1ns/100ps
module wsh_steering_properties
  import wsh_pkg::*;
#(parameter int NUM_SECONDARY = NUM_SEC) (
  input logic clock,
  input logic reset,
  input wsh_req_s busReq,
  input wsh_rsp_s busRsp,
  input logic highPrioIrqIn_n,
  input logic [NUM_SECONDARY-1:0] secIrqIn_n,
  input logic watchdogExpire,
  input logic watchdogEnabled,
  input logic normalIrq,
  input logic fastIrq,
  input logic [1:0] watchdogPriority,
  input logic chipResetReq,
  input logic eventIrq
);
  logic wd;
  logic hp;
  logic [NUM_SECONDARY-1:0] sm;
  logic [1:0] pr;
  logic fire;
  logic anyIrq;
  logic done;
  assign fire = watchdogExpire && watchdogEnabled;
  assign anyIrq = normalIrq || fastIrq;
  assign done = busReq.write && !busRsp.waitrequest;
  // Mask bits are shadowed from the bus, since the checker cannot see inside.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wd <= 1'b0;
      hp <= 1'b0;
      sm <= '0;
      pr <= 2'h0;
    end else if (done && busReq.address == OFS_CONTROL_0) begin
      wd <= busReq.writedata[BIT_WATCHDOG];
    end else if (done && busReq.address == OFS_CONTROL_1) begin
      hp <= busReq.writedata[BIT_HIGH_PRIO];
      sm <= busReq.writedata[NUM_SECONDARY-1:0];
    end else if (done && busReq.address == OFS_PRIORITY_1) begin
      pr <= busReq.writedata[PRIO_WDOG_HI:PRIO_WDOG_LO];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  chk_all_masked_quiet: assert property (!hp && sm == '0 && !wd |-> !anyIrq)
    else $error("core irq with every source masked");
  chk_high_prio_on: assert property (hp && !highPrioIrqIn_n |-> anyIrq)
    else $error("unmasked high priority pin gave no irq");
  chk_secondary_on: assert property (|(sm & ~secIrqIn_n) |-> anyIrq)
    else $error("unmasked secondary pin gave no irq");
  chk_prio_field: assert property (watchdogPriority == pr)
    else $error("watchdog priority differs from its field");
  chk_expiry_reset: assert property (fire && !wd |=> chipResetReq ##1 !chipResetReq)
    else $error("expiry steered to reset gave no single pulse");
  chk_expiry_irq: assert property (fire && wd |=> !chipResetReq && anyIrq)
    else $error("expiry steered to irq misbehaved");
  chk_reset_cause: assert property (chipResetReq |-> $past(fire && !wd))
    else $error("chip reset without a steered expiry");
  chk_disabled_quiet: assert property (watchdogExpire && !watchdogEnabled |=> !chipResetReq)
    else $error("disabled watchdog caused a reset");
endmodule
bind wsh_steering wsh_steering_properties #(.NUM_SECONDARY(NUM_SECONDARY)) u_chk (.clock(clock),
  .reset(reset), .busReq(busReq), .busRsp(busRsp), .highPrioIrqIn_n(highPrioIrqIn_n), .secIrqIn_n(secIrqIn_n),
  .watchdogExpire(watchdogExpire), .watchdogEnabled(watchdogEnabled), .normalIrq(normalIrq),
  .fastIrq(fastIrq), .watchdogPriority(watchdogPriority), .chipResetReq(chipResetReq), .eventIrq(eventIrq));

/* File: dv/wsh_core_model.sv */
/* Processor core stand-in: counts chip resets taken.
   Assumes chipResetReq is a one-cycle pulse on clock. */
`timescale 1ns/100ps
module wsh_core_model (
  input wire logic clock,
  input wire logic reset,
  input wire logic chipResetReq,
  output logic [7:0] resetCount
);
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      resetCount <= 8'h00;
    end else if (chipResetReq) begin
      resetCount <= resetCount + 8'h01;
    end
  end
endmodule

/* File: dv/wsh_steering_bench.sv */
/* Self-checking bench for wsh_steering.
   Assumes the checker is bound and the core model counts resets. */
`timescale 1ns/100ps
module wsh_steering_bench import wsh_pkg::*;;
  logic clock = 1'b0;
  logic reset = 1'b1;
  wsh_req_s rq = '0;
  wsh_rsp_s rs;
  logic hpN = 1'b0;
  logic [3:0] secN = 4'h0;
  logic ex = 1'b0;
  logic en = 1'b0;
  logic nIrq, fIrq, crr, eIrq;
  logic [1:0] pri;
  logic [7:0] resets;
  logic [31:0] d;
  int num_errors = 0;
  int samples_checked = 0;
  always #5 clock = ~clock;
  wsh_steering u_dut (.clock(clock), .reset(reset), .busReq(rq), .busRsp(rs), .highPrioIrqIn_n(hpN),
    .secIrqIn_n(secN), .watchdogExpire(ex), .watchdogEnabled(en), .normalIrq(nIrq), .fastIrq(fIrq),
    .watchdogPriority(pri), .chipResetReq(crr), .eventIrq(eIrq));
  wsh_core_model u_core (.clock(clock), .reset(reset), .chipResetReq(crr), .resetCount(resets));
  task stop_test;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task ck(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // Starting with an edge keeps a new request off the step where the last one was released.
  task bus(input logic w, input logic [4:0] a, input logic [31:0] wd);
    @(posedge clock);
    rq <= '{~w, w, a, 4'hf, wd};
    do @(posedge clock); while (rs.waitrequest !== 1'b0);
    d = rs.readdata;
    rq <= '0;
    @(posedge clock);
  endtask
  task pulse(input logic e);
    @(posedge clock);
    ex <= 1'b1;
    en <= e;
    @(posedge clock);
    ex <= 1'b0;
    @(negedge clock);
  endtask
  task t_reset;
    bus(0, OFS_CONTROL_1, 0); ck(d, RST_CONTROL);
    bus(0, OFS_CONTROL_0, 0); ck(d, RST_CONTROL);
    bus(0, 5'h02, 0); ck(d, READ_UNMAPPED);
    ck({nIrq, fIrq}, 2'b00);
  endtask
  task t_pins;
    for (int i = 0; i < 5; i++) begin
      bus(1, OFS_CONTROL_1, 32'h1 << (i < 4 ? i : BIT_HIGH_PRIO)); ck({nIrq, fIrq}, 2'b10);
      bus(1, OFS_STEERING_0, 32'h1 << (i < 4 ? i : BIT_HIGH_PRIO)); ck({nIrq, fIrq}, 2'b01);
      bus(0, OFS_FAST_SRC_0, 0); ck(d, 32'h1 << (i < 4 ? i : BIT_HIGH_PRIO));
      bus(1, OFS_STEERING_0, 0);
    end
    hpN <= 1'b1;
    @(negedge clock); ck({nIrq, fIrq}, 2'b00);
    bus(1, OFS_CONTROL_1, 0); ck({nIrq, fIrq}, 2'b00);
  endtask
  task t_wdog;
    pulse(0); ck(crr, 0);
    pulse(1); ck(crr, 1);
    @(negedge clock); ck(crr, 0); ck(resets, 1);
    bus(0, OFS_EVENT_STATUS, 0); ck(d[EVT_RESET_TAKEN], 1);
    bus(1, OFS_CONTROL_0, 32'h1 << BIT_WATCHDOG);
    pulse(1); ck({crr, nIrq}, 2'b01);
    bus(0, OFS_NORMAL_SRC_0, 0); ck(d[BIT_WATCHDOG], 1);
    bus(1, OFS_NORMAL_SRC_0, 32'h1 << BIT_WATCHDOG); ck({nIrq, resets}, 9'h001);
  endtask
  task t_event;
    ck(eIrq, 0);
    bus(1, OFS_EVENT_MASK, 32'h1); ck(eIrq, 1);
    bus(1, OFS_EVENT_STATUS, 32'h7); ck(eIrq, 0);
    bus(1, OFS_PRIORITY_1, 32'h8); ck(pri, 2'h2);
    bus(0, OFS_PRIORITY_1, 0); ck(d, 32'h8);
  endtask
  initial begin
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    t_reset;
    t_pins;
    t_wdog;
    t_event;
    stop_test;
  end
  // The whole run needs about 150 cycles; this bound cuts a hung handshake short.
  initial begin
    repeat (5000) @(posedge clock);
    num_errors++;
    stop_test;
  end
endmodule
